/* File: core/ccra_addr_gen.sv */
// Purpose: Forms the operand space and address for each addressing mode.
// Assumes: Register and pointer values are current state of the top module.
// Notes: Combinational; the top module registers the result.
`timescale 1ns/10ps
module ccra_addr_gen (
	input wire logic [3:0] mode_i,
	input wire logic [7:0] field_i,
	input wire logic ext_i,
	input wire logic [7:0] ri_val_i,
	input wire logic [7:0] stack_i,
	input wire logic [15:0] data_pointer_16_i,
	input wire logic [7:0] acc_i,
	input wire logic [15:0] pc_i,
	input wire logic [1:0] bank_i,
	output logic [2:0] space_o,
	output logic [15:0] addr_o,
	output logic local_o,
	output logic wr_ok_o
);
	logic [15:0] acc_wide;
	logic sfr_hit;

	assign acc_wide = {ccra_pkg::HIGH_ZERO, acc_i};
	assign sfr_hit = (field_i == ccra_pkg::OFS_STACK) || (field_i == ccra_pkg::OFS_DPL) ||
		(field_i == ccra_pkg::OFS_DPH) || (field_i == ccra_pkg::OFS_FLAGS) ||
		(field_i == ccra_pkg::OFS_MAIN) || (field_i == ccra_pkg::OFS_SECOND);

	always_comb begin
		space_o = ccra_pkg::SPACE_NONE;
		addr_o = ccra_pkg::RST_ZERO16;
		local_o = 1'b0;
		wr_ok_o = 1'b1;
		case (mode_i)
			ccra_pkg::MODE_DIR: begin
				// Upper half goes to special registers, never upper RAM
				addr_o = {ccra_pkg::HIGH_ZERO, field_i};
				if (field_i >= ccra_pkg::SFR_BASE) begin
					space_o = ccra_pkg::SPACE_SFR;
					local_o = sfr_hit;
				end else begin
					space_o = ccra_pkg::SPACE_IRAM;
				end
			end
			ccra_pkg::MODE_IND_RI: begin
				space_o = ext_i ? ccra_pkg::SPACE_XRAM : ccra_pkg::SPACE_IRAM;
				addr_o = {ccra_pkg::HIGH_ZERO, ri_val_i};
			end
			ccra_pkg::MODE_PUSH: begin
				space_o = ccra_pkg::SPACE_IRAM;
				addr_o = {ccra_pkg::HIGH_ZERO, stack_i + ccra_pkg::STACK_STEP};
			end
			ccra_pkg::MODE_POP: begin
				space_o = ccra_pkg::SPACE_IRAM;
				addr_o = {ccra_pkg::HIGH_ZERO, stack_i};
			end
			ccra_pkg::MODE_IND_DATA_POINTER_16: begin
				space_o = ccra_pkg::SPACE_XRAM;
				addr_o = data_pointer_16_i;
			end
			ccra_pkg::MODE_REG: begin
				space_o = ccra_pkg::SPACE_IRAM;
				addr_o = {ccra_pkg::HIGH_ZERO, ccra_pkg::BANK_TOP_ZERO, bank_i,
					field_i[2:0]};
			end
			ccra_pkg::MODE_RSPEC: begin
				local_o = 1'b1;
			end
			ccra_pkg::MODE_IMM: begin
				space_o = ccra_pkg::SPACE_CODE;
				addr_o = pc_i + ccra_pkg::ADDR_STEP;
				wr_ok_o = 1'b0;
			end
			ccra_pkg::MODE_IDX_DATA_POINTER_16: begin
				space_o = ccra_pkg::SPACE_CODE;
				addr_o = data_pointer_16_i + acc_wide;
				wr_ok_o = 1'b0;
			end
			ccra_pkg::MODE_IDX_PC: begin
				space_o = ccra_pkg::SPACE_CODE;
				addr_o = pc_i + acc_wide;
				wr_ok_o = 1'b0;
			end
			ccra_pkg::MODE_JMP_IDX: begin
				addr_o = data_pointer_16_i + acc_wide;
				local_o = 1'b1;
				wr_ok_o = 1'b0;
			end
			ccra_pkg::MODE_DATA_POINTER_16_INC,
			ccra_pkg::MODE_DATA_POINTER_16_LOAD: begin
				local_o = 1'b1;
			end
			default: begin
				space_o = ccra_pkg::SPACE_NONE;
				wr_ok_o = 1'b0;
			end
		endcase
	end
endmodule

/* File: core/ccra_core_regs.sv */
// Purpose: CPU core registers, flag word and operand address formation.
// Assumes: Pipeline requests are synchronous to ref_clk_i.
// Notes: Register banks live in internal RAM outside this block.
`timescale 1ns/10ps
module ccra_core_regs #(
	parameter int unsigned DATA_W = ccra_pkg::DATA_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic [3:0] req_mode_i,
	input wire logic [7:0] req_field_i,
	input wire logic req_write_i,
	input wire logic req_ext_i,
	input wire logic [7:0] req_wdata_i,
	input wire logic [15:0] req_imm16_i,
	input wire logic [2:0] req_cycles_i,
	input wire logic [7:0] ri_val_i,
	input wire logic [15:0] pc_i,
	input wire logic acc_we_i,
	input wire logic [7:0] acc_wdata_i,
	input wire logic b_we_i,
	input wire logic [7:0] b_wdata_i,
	input wire logic alu_flags_we_i,
	input wire logic alu_cy_i,
	input wire logic alu_ac_i,
	input wire logic alu_ov_i,
	input wire logic [2:0] bit_op_i,
	input wire logic bit_in_i,
	output logic req_ready_o,
	output logic done_o,
	output logic mem_valid_o,
	output logic [2:0] mem_space_o,
	output logic [15:0] mem_addr_o,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic jmp_valid_o,
	output logic [15:0] jmp_target_o,
	output logic [7:0] main_operand_o,
	output logic [7:0] second_operand_o,
	output logic [7:0] stack_top_pointer_o,
	output logic [15:0] data_pointer_16_o,
	output logic [7:0] cpu_flags_word_o,
	output logic [1:0] bank_select_o,
	output logic carry_flag_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Request acceptance and addressing
	logic [7:0] main_operand_reg;
	logic [7:0] main_operand_next;
	logic [7:0] second_operand_reg;
	logic [7:0] stack_top_pointer_reg;
	logic [7:0] data_pointer_low_reg;
	logic [7:0] data_pointer_high_reg;
	logic [7:0] cpu_flags_word_reg;
	logic [2:0] cyc_cnt_reg;
	logic busy_reg;
	logic done_reg;
	logic accept;
	logic [2:0] space;
	logic [15:0] addr;
	logic local_hit;
	logic wr_ok;
	logic parity_next;
	logic [15:0] data_pointer_16;
	logic [1:0] bank;
	logic sfr_wr;
	logic rspec_wr;
	logic [7:0] local_rdata;
	logic carry_bit;

	assign accept = req_valid_i && !busy_reg;
	assign data_pointer_16 = {data_pointer_high_reg, data_pointer_low_reg};
	assign bank = {cpu_flags_word_reg[ccra_pkg::BIT_BANK_HI],
		cpu_flags_word_reg[ccra_pkg::BIT_BANK_LO]};
	assign carry_bit = cpu_flags_word_reg[ccra_pkg::BIT_CY];
	assign sfr_wr = accept && req_write_i && local_hit && (req_mode_i == ccra_pkg::MODE_DIR);
	assign rspec_wr = accept && req_write_i && (req_mode_i == ccra_pkg::MODE_RSPEC);

	ccra_addr_gen u_addr_gen (
		.mode_i(req_mode_i),
		.field_i(req_field_i),
		.ext_i(req_ext_i),
		.ri_val_i(ri_val_i),
		.stack_i(stack_top_pointer_reg),
		.data_pointer_16_i(data_pointer_16),
		.acc_i(main_operand_reg),
		.pc_i(pc_i),
		.bank_i(bank),
		.space_o(space),
		.addr_o(addr),
		.local_o(local_hit),
		.wr_ok_o(wr_ok)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Instruction cycle counter
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_cnt_reg <= ccra_pkg::CYC_NONE;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (accept) begin
			// A zero count is held to the one-cycle minimum
			if (req_cycles_i <= ccra_pkg::CYC_MIN) begin
				cyc_cnt_reg <= ccra_pkg::CYC_NONE;
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
			end else begin
				cyc_cnt_reg <= req_cycles_i - ccra_pkg::CYC_ONE;
				busy_reg <= 1'b1;
				done_reg <= 1'b0;
			end
		end else if (cyc_cnt_reg != ccra_pkg::CYC_NONE) begin
			cyc_cnt_reg <= cyc_cnt_reg - ccra_pkg::CYC_ONE;
			busy_reg <= (cyc_cnt_reg != ccra_pkg::CYC_ONE);
			done_reg <= (cyc_cnt_reg == ccra_pkg::CYC_ONE);
		end else begin
			done_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main operand register and its parity
	always_comb begin
		main_operand_next = main_operand_reg;
		if (rspec_wr && !req_field_i[0]) begin
			main_operand_next = req_wdata_i;
		end else if (acc_we_i) begin
			main_operand_next = acc_wdata_i;
		end
	end

	ccra_parity #(
		.WIDTH(DATA_W)
	) u_parity (
		.data_i(main_operand_next),
		.odd_o(parity_next)
	);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			main_operand_reg <= ccra_pkg::RST_ZERO;
		end else begin
			main_operand_reg <= main_operand_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Second operand register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			second_operand_reg <= ccra_pkg::RST_ZERO;
		end else if (rspec_wr && req_field_i[0]) begin
			second_operand_reg <= req_wdata_i;
		end else if (sfr_wr && (req_field_i == ccra_pkg::OFS_SECOND)) begin
			second_operand_reg <= req_wdata_i;
		end else if (b_we_i) begin
			second_operand_reg <= b_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stack pointer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stack_top_pointer_reg <= ccra_pkg::RST_STACK;
		end else if (accept && (req_mode_i == ccra_pkg::MODE_PUSH)) begin
			stack_top_pointer_reg <= stack_top_pointer_reg + ccra_pkg::STACK_STEP;
		end else if (accept && (req_mode_i == ccra_pkg::MODE_POP)) begin
			stack_top_pointer_reg <= stack_top_pointer_reg - ccra_pkg::STACK_STEP;
		end else if (sfr_wr && (req_field_i == ccra_pkg::OFS_STACK)) begin
			stack_top_pointer_reg <= req_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data pointer
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_pointer_low_reg <= ccra_pkg::RST_ZERO;
			data_pointer_high_reg <= ccra_pkg::RST_ZERO;
		end else if (accept && (req_mode_i == ccra_pkg::MODE_DATA_POINTER_16_INC)) begin
			{data_pointer_high_reg, data_pointer_low_reg} <= data_pointer_16 + ccra_pkg::ADDR_STEP;
		end else if (accept && (req_mode_i == ccra_pkg::MODE_DATA_POINTER_16_LOAD)) begin
			{data_pointer_high_reg, data_pointer_low_reg} <= req_imm16_i;
		end else if (sfr_wr && (req_field_i == ccra_pkg::OFS_DPL)) begin
			data_pointer_low_reg <= req_wdata_i;
		end else if (sfr_wr && (req_field_i == ccra_pkg::OFS_DPH)) begin
			data_pointer_high_reg <= req_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flag word
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_flags_word_reg <= ccra_pkg::RST_ZERO;
		end else begin
			if (sfr_wr && (req_field_i == ccra_pkg::OFS_FLAGS)) begin
				cpu_flags_word_reg[ccra_pkg::BIT_CY:ccra_pkg::BIT_F1] <=
					req_wdata_i[ccra_pkg::BIT_CY:ccra_pkg::BIT_F1];
			end
			if (alu_flags_we_i) begin
				cpu_flags_word_reg[ccra_pkg::BIT_CY] <= alu_cy_i;
				cpu_flags_word_reg[ccra_pkg::BIT_AC] <= alu_ac_i;
				cpu_flags_word_reg[ccra_pkg::BIT_OV] <= alu_ov_i;
			end
			// Boolean work on carry overrides an arithmetic carry
			case (bit_op_i)
				ccra_pkg::BOP_CLR: cpu_flags_word_reg[ccra_pkg::BIT_CY] <= 1'b0;
				ccra_pkg::BOP_SET: cpu_flags_word_reg[ccra_pkg::BIT_CY] <= 1'b1;
				ccra_pkg::BOP_CPL: cpu_flags_word_reg[ccra_pkg::BIT_CY] <= !carry_bit;
				ccra_pkg::BOP_MOV: cpu_flags_word_reg[ccra_pkg::BIT_CY] <= bit_in_i;
				ccra_pkg::BOP_ANL: begin
					cpu_flags_word_reg[ccra_pkg::BIT_CY] <= carry_bit & bit_in_i;
				end
				ccra_pkg::BOP_ORL: begin
					cpu_flags_word_reg[ccra_pkg::BIT_CY] <= carry_bit | bit_in_i;
				end
				default: begin
				end
			endcase
			// Parity cannot be written; it always mirrors the main operand
			cpu_flags_word_reg[ccra_pkg::BIT_PAR] <= parity_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Local read data
	always_comb begin
		local_rdata = ccra_pkg::RST_ZERO;
		if (req_mode_i == ccra_pkg::MODE_RSPEC) begin
			local_rdata = req_field_i[0] ? second_operand_reg : main_operand_reg;
		end else begin
			case (req_field_i)
				ccra_pkg::OFS_STACK: local_rdata = stack_top_pointer_reg;
				ccra_pkg::OFS_DPL: local_rdata = data_pointer_low_reg;
				ccra_pkg::OFS_DPH: local_rdata = data_pointer_high_reg;
				ccra_pkg::OFS_FLAGS: local_rdata = cpu_flags_word_reg;
				ccra_pkg::OFS_SECOND: local_rdata = second_operand_reg;
				default: local_rdata = ccra_pkg::RST_ZERO;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand access outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_valid_o <= 1'b0;
			mem_space_o <= ccra_pkg::SPACE_NONE;
			mem_addr_o <= ccra_pkg::RST_ZERO16;
			mem_wr_o <= 1'b0;
			mem_wdata_o <= ccra_pkg::RST_ZERO;
		end else if (accept && !local_hit && (space != ccra_pkg::SPACE_NONE)) begin
			mem_valid_o <= 1'b1;
			mem_space_o <= space;
			mem_addr_o <= addr;
			mem_wr_o <= (req_mode_i == ccra_pkg::MODE_PUSH) ||
				(req_write_i && wr_ok && (req_mode_i != ccra_pkg::MODE_POP));
			mem_wdata_o <= req_wdata_i;
		end else begin
			mem_valid_o <= 1'b0;
			mem_wr_o <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o <= ccra_pkg::RST_ZERO;
		end else if (accept && !req_write_i && ((req_mode_i == ccra_pkg::MODE_RSPEC) ||
			(local_hit && (req_mode_i == ccra_pkg::MODE_DIR)))) begin
			rd_valid_o <= 1'b1;
			rd_data_o <= local_rdata;
		end else begin
			rd_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			jmp_valid_o <= 1'b0;
			jmp_target_o <= ccra_pkg::RST_ZERO16;
		end else if (accept && (req_mode_i == ccra_pkg::MODE_JMP_IDX)) begin
			jmp_valid_o <= 1'b1;
			jmp_target_o <= addr;
		end else begin
			jmp_valid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register views
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_ready_o <= 1'b1;
			done_o <= 1'b0;
		end else begin
			req_ready_o <= !busy_reg;
			done_o <= done_reg;
		end
	end

	assign main_operand_o = main_operand_reg;
	assign second_operand_o = second_operand_reg;
	assign stack_top_pointer_o = stack_top_pointer_reg;
	assign data_pointer_16_o = data_pointer_16;
	assign cpu_flags_word_o = cpu_flags_word_reg;
	assign bank_select_o = bank;
	assign carry_flag_o = carry_bit;
endmodule

/* File: core/ccra_parity.sv */
// Purpose: Odd-ones detector over a data word.
// Assumes: Purely combinational.
// Notes: One generate stage per bit.
`timescale 1ns/10ps
module ccra_parity #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic [WIDTH-1:0] data_i,
	output logic odd_o
);
	logic [WIDTH:0] chain;

	assign chain[0] = 1'b0;
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign chain[i+1] = chain[i] ^ data_i[i];
	end
	assign odd_o = chain[WIDTH];
endmodule

/* File: dv/ccra_core_regs_chk.sv */
// Purpose: Port-level assertions for the core register and addressing block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Request causes are read with $past, one cycle before the answer pulse.
`timescale 1ns/10ps
module ccra_core_regs_chk (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] req_mode_i,
	input wire logic [7:0] req_field_i,
	input wire logic req_ext_i,
	input wire logic [7:0] ri_val_i,
	input wire logic [15:0] pc_i,
	input wire logic [2:0] bit_op_i,
	input wire logic mem_valid_o,
	input wire logic [2:0] mem_space_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_wr_o,
	input wire logic jmp_valid_o,
	input wire logic [15:0] jmp_target_o,
	input wire logic [7:0] main_operand_o,
	input wire logic [7:0] stack_top_pointer_o,
	input wire logic [15:0] data_pointer_16_o,
	input wire logic [7:0] cpu_flags_word_o,
	input wire logic [1:0] bank_select_o,
	input wire logic carry_flag_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	parity_track_a: assert property (cpu_flags_word_o[0] == ^main_operand_o)
		else $error("parity flag differs from main operand");
	reg_bank_a: assert property (mem_valid_o && $past(req_mode_i) == 4'h5 |->
		mem_space_o == 3'h1
		&& mem_addr_o == {11'h000, $past(bank_select_o), $past(req_field_i[2:0])})
		else $error("register address wrong");
	carry_cpl_a: assert property ($past(bit_op_i) == 3'h3 |->
		carry_flag_o != $past(carry_flag_o)) else $error("carry complement wrong");
	push_order_a: assert property (mem_valid_o && $past(req_mode_i) == 4'h2 |->
		mem_wr_o && stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01
		&& mem_addr_o == {8'h00, stack_top_pointer_o}) else $error("push order wrong");
	dir_space_a: assert property (mem_valid_o && $past(req_mode_i) == 4'h0 |->
		mem_addr_o == {8'h00, $past(req_field_i)}
		&& mem_space_o == ($past(req_field_i[7]) ? 3'h2 : 3'h1)) else $error("direct wrong");
	ind_space_a: assert property (mem_valid_o && $past(req_mode_i) == 4'h1 |->
		mem_addr_o == {8'h00, $past(ri_val_i)}
		&& mem_space_o == ($past(req_ext_i) ? 3'h3 : 3'h1)) else $error("indirect wrong");
	imm_code_a: assert property (mem_valid_o && $past(req_mode_i) == 4'h7 |->
		!mem_wr_o && mem_space_o == 3'h4 && mem_addr_o == $past(pc_i) + 16'h0001)
		else $error("immediate fetch wrong");
	idx_read_a: assert property (mem_valid_o && $past(req_mode_i) == 4'h8 |->
		!mem_wr_o && mem_space_o == 3'h4
		&& mem_addr_o == $past(data_pointer_16_o) + {8'h00, $past(main_operand_o)})
		else $error("indexed read wrong");
	jump_sum_a: assert property (jmp_valid_o |->
		jmp_target_o == $past(data_pointer_16_o) + {8'h00, $past(main_operand_o)})
		else $error("jump target wrong");
endmodule
bind ccra_core_regs ccra_core_regs_chk chk_u (.ref_clk_i, .rst_n_i, .req_mode_i, .req_field_i,
	.req_ext_i, .ri_val_i, .pc_i, .bit_op_i, .mem_valid_o, .mem_space_o, .mem_addr_o, .mem_wr_o,
	.jmp_valid_o, .jmp_target_o, .main_operand_o, .stack_top_pointer_o, .data_pointer_16_o,
	.cpu_flags_word_o, .bank_select_o, .carry_flag_o);

/* File: dv/ccra_iram_model.sv */
// Purpose: Internal RAM model holding the register banks.
// Assumes: Writes arrive as one-cycle pulses from the block.
// Notes: Read of R0 or R1 is combinational.
`timescale 1ns/10ps
module ccra_iram_model (
	input wire logic clk_i,
	input wire logic mem_valid_i,
	input wire logic [2:0] mem_space_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic mem_wr_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic [1:0] bank_i,
	input wire logic sel_i,
	output logic [7:0] ri_val_o
);
	logic [7:0] ram_reg [256];
	initial begin
		for (int i = 0; i < 256; i++) ram_reg[i] = 8'h00;
	end
	always @(posedge clk_i) begin
		if (mem_valid_i && mem_wr_i && mem_space_i == ccra_pkg::SPACE_IRAM) begin
			ram_reg[mem_addr_i[7:0]] <= mem_wdata_i;
		end
	end
	// Pointer registers of the selected bank sit in the lowest 32 bytes
	assign ri_val_o = ram_reg[{3'h0, bank_i, 2'h0, sel_i}];
endmodule

/* File: dv/test_cpu_core_registers_addressing.sv */
// Purpose: Self-checking bench for the core register and addressing block.
// Assumes: Requests held until the taking edge, inputs moved 1 ns after the edge.
// Notes: Checks made in the cycle after the taking edge.
`timescale 1ns/10ps
module test_cpu_core_registers_addressing;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
	logic req_ext_i = 1'b0, acc_we_i = 1'b0, b_we_i = 1'b0, alu_flags_we_i = 1'b0;
	logic alu_cy_i = 1'b0, alu_ac_i = 1'b0, alu_ov_i = 1'b0, bit_in_i = 1'b0;
	logic [3:0] req_mode_i = 4'h0;
	logic [2:0] req_cycles_i = 3'h1, bit_op_i = 3'h0;
	logic [7:0] req_field_i = 8'h00, req_wdata_i = 8'h00, acc_wdata_i = 8'h00, b_wdata_i = 8'h00;
	logic [15:0] req_imm16_i = 16'h0000, pc_i = 16'h0000;
	logic [7:0] ri_val_i, mem_wdata_o, rd_data_o, main_operand_o, second_operand_o;
	logic [7:0] stack_top_pointer_o, cpu_flags_word_o;
	logic [15:0] mem_addr_o, jmp_target_o, data_pointer_16_o;
	logic [2:0] mem_space_o;
	logic [1:0] bank_select_o;
	logic req_ready_o, done_o, mem_valid_o, mem_wr_o, rd_valid_o, jmp_valid_o, carry_flag_o;
	int n_errors = 0, comparisons = 0, cycles = 0;
	ccra_core_regs dut_u (.ref_clk_i, .rst_n_i, .req_valid_i, .req_mode_i, .req_field_i,
		.req_write_i, .req_ext_i, .req_wdata_i, .req_imm16_i, .req_cycles_i, .ri_val_i, .pc_i,
		.acc_we_i, .acc_wdata_i, .b_we_i, .b_wdata_i, .alu_flags_we_i, .alu_cy_i, .alu_ac_i,
		.alu_ov_i, .bit_op_i, .bit_in_i, .req_ready_o, .done_o, .mem_valid_o, .mem_space_o,
		.mem_addr_o, .mem_wr_o, .mem_wdata_o, .rd_valid_o, .rd_data_o, .jmp_valid_o,
		.jmp_target_o, .main_operand_o, .second_operand_o, .stack_top_pointer_o,
		.data_pointer_16_o, .cpu_flags_word_o, .bank_select_o, .carry_flag_o);
	ccra_iram_model mem_u (.clk_i(ref_clk_i), .mem_valid_i(mem_valid_o), .mem_space_i(mem_space_o),
		.mem_addr_i(mem_addr_o), .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o),
		.bank_i(bank_select_o), .sel_i(req_field_i[0]), .ri_val_o(ri_val_i));
	initial begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick;
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic issue(input ccra_pkg::ccra_mode_t m, input logic [7:0] f,
		input logic w = 1'b0, input logic [7:0] d = 8'h00, input logic [2:0] n = 3'h1);
		req_valid_i = 1'b1;
		req_mode_i = m;
		req_field_i = f;
		req_write_i = w;
		req_wdata_i = d;
		req_cycles_i = n;
		tick;
	endtask
	task automatic idle;
		req_valid_i = 1'b0;
		tick;
	endtask
	task automatic mem(input logic [2:0] sp, input logic [15:0] a, input logic w);
		check("mem_valid", mem_valid_o, 1'b1);
		check("mem_space", mem_space_o, sp);
		check("mem_addr", mem_addr_o, a);
		check("mem_wr", mem_wr_o, w);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("stack", stack_top_pointer_o, 16'h0007);
		check("data_pointer_16", data_pointer_16_o, 16'h0000);
		check("flags", cpu_flags_word_o, 16'h0000);
		check("second", second_operand_o, 16'h0000);
		issue(ccra_pkg::MODE_DIR, 8'h81);
		check("rd_data", rd_data_o, 16'h0007);
		check("rd_valid", rd_valid_o, 1'b1);
		idle;
	endtask
	task automatic t_stack;
		issue(ccra_pkg::MODE_PUSH, 8'h00, 1'b1, 8'hA5);
		mem(3'h1, 16'h0008, 1'b1);
		check("push_data", mem_wdata_o, 16'h00A5);
		issue(ccra_pkg::MODE_PUSH, 8'h00, 1'b1, 8'h5A);
		mem(3'h1, 16'h0009, 1'b1);
		issue(ccra_pkg::MODE_POP, 8'h00);
		mem(3'h1, 16'h0009, 1'b0);
		check("stack", stack_top_pointer_o, 16'h0008);
		idle;
	endtask
	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			issue(ccra_pkg::MODE_DIR, 8'hD0, 1'b1, {3'h0, b[1:0], 3'h0});
			issue(ccra_pkg::MODE_REG, 8'hFE);
			check("bank", bank_select_o, b[1:0]);
			mem(3'h1, 16'(b * 8 + 6), 1'b0);
		end
		issue(ccra_pkg::MODE_DIR, 8'hD0, 1'b1, 8'hFF);
		check("flags", cpu_flags_word_o, 16'h00FE);
		check("carry", carry_flag_o, 1'b1);
		issue(ccra_pkg::MODE_DIR, 8'hD0, 1'b1, 8'h00);
		idle;
	endtask
	task automatic t_operands;
		acc_we_i = 1'b1;
		acc_wdata_i = 8'h07;
		tick;
		acc_we_i = 1'b0;
		check("parity", cpu_flags_word_o[0], 1'b1);
		issue(ccra_pkg::MODE_RSPEC, 8'h00, 1'b1, 8'h03);
		check("main", main_operand_o, 16'h0003);
		check("parity", cpu_flags_word_o[0], 1'b0);
		issue(ccra_pkg::MODE_RSPEC, 8'h01, 1'b1, 8'h3C);
		check("second", second_operand_o, 16'h003C);
		issue(ccra_pkg::MODE_DIR, 8'hF0, 1'b1, 8'h81);
		check("second", second_operand_o, 16'h0081);
		idle;
		b_we_i = 1'b1;
		b_wdata_i = 8'h42;
		tick;
		b_we_i = 1'b0;
		check("second", second_operand_o, 16'h0042);
	endtask
	task automatic t_carry;
		logic [2:0] ops [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
		logic ins [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		logic exps [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 6; i++) begin
			bit_op_i = ops[i];
			bit_in_i = ins[i];
			tick;
			check("carry", carry_flag_o, exps[i]);
		end
		bit_op_i = 3'h0;
		alu_flags_we_i = 1'b1;
		alu_ac_i = 1'b1;
		alu_ov_i = 1'b1;
		tick;
		alu_flags_we_i = 1'b0;
		check("flags", cpu_flags_word_o, 16'h0044);
	endtask
	task automatic t_pointer;
		req_imm16_i = 16'h12FF;
		pc_i = 16'h0400;
		issue(ccra_pkg::MODE_DATA_POINTER_16_LOAD, 8'h00);
		check("data_pointer_16", data_pointer_16_o, 16'h12FF);
		issue(ccra_pkg::MODE_DATA_POINTER_16_INC, 8'h00);
		check("data_pointer_16", data_pointer_16_o, 16'h1300);
		issue(ccra_pkg::MODE_DIR, 8'h83);
		check("rd_data", rd_data_o, 16'h0013);
		issue(ccra_pkg::MODE_IND_DATA_POINTER_16, 8'h00, 1'b1, 8'h5A);
		mem(3'h3, 16'h1300, 1'b1);
		check("rd_valid", rd_valid_o, 1'b0);
		issue(ccra_pkg::MODE_IDX_DATA_POINTER_16, 8'h00, 1'b1);
		mem(3'h4, 16'h1303, 1'b0);
		issue(ccra_pkg::MODE_IDX_PC, 8'h00);
		mem(3'h4, 16'h0403, 1'b0);
		issue(ccra_pkg::MODE_IMM, 8'h00, 1'b1);
		mem(3'h4, 16'h0401, 1'b0);
		issue(ccra_pkg::MODE_JMP_IDX, 8'h00);
		check("jmp_valid", jmp_valid_o, 1'b1);
		check("jmp_target", jmp_target_o, 16'h1303);
		idle;
	endtask
	task automatic t_direct;
		issue(ccra_pkg::MODE_DIR, 8'h00, 1'b1, 8'h90);
		mem(3'h1, 16'h0000, 1'b1);
		issue(ccra_pkg::MODE_DIR, 8'hA0);
		mem(3'h2, 16'h00A0, 1'b0);
		issue(ccra_pkg::MODE_IND_RI, 8'h00);
		mem(3'h1, 16'h0090, 1'b0);
		req_ext_i = 1'b1;
		issue(ccra_pkg::MODE_IND_RI, 8'h00);
		mem(3'h3, 16'h0090, 1'b0);
		req_ext_i = 1'b0;
		idle;
	endtask
	task automatic t_cycles;
		issue(ccra_pkg::MODE_PUSH, 8'h00, 1'b1, 8'h11, 3'h7);
		tick;
		check("ready", req_ready_o, 1'b0);
		repeat (5) tick;
		check("done", done_o, 1'b0);
		idle;
		check("done", done_o, 1'b1);
		check("ready", req_ready_o, 1'b1);
		check("stack", stack_top_pointer_o, 16'h0009);
		issue(ccra_pkg::MODE_PUSH, 8'h00, 1'b1, 8'h22);
		repeat (2) tick;
		idle;
		check("stack", stack_top_pointer_o, 16'h000C);
	endtask
	task automatic t_rerun;
		rst_n_i = 1'b0;
		tick;
		rst_n_i = 1'b1;
		check("stack", stack_top_pointer_o, 16'h0007);
		check("data_pointer_16", data_pointer_16_o, 16'h0000);
		check("second", second_operand_o, 16'h0000);
		check("flags", cpu_flags_word_o, 16'h0000);
		issue(ccra_pkg::MODE_PUSH, 8'h00, 1'b1, 8'h33);
		mem(3'h1, 16'h0008, 1'b1);
		idle;
	endtask
	initial begin
		repeat (8) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		t_reset;
		t_stack;
		t_banks;
		t_operands;
		t_carry;
		t_pointer;
		t_direct;
		t_cycles;
		t_rerun;
		complete_run;
	end
endmodule

/* File: include/ccra_pkg.sv */
// Purpose: Shared constants and types for the CPU core register set and addressing.
// Assumes: 8-bit data path, 16-bit code and expanded-RAM addresses.
// Notes: Offsets are direct special-register addresses.
package ccra_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned BANK_W = 2;
	localparam int unsigned REG_SEL_W = 3;
	localparam int unsigned CYC_W = 3;

	localparam logic [7:0] OFS_STACK = 8'h81;
	localparam logic [7:0] OFS_DPL = 8'h82;
	localparam logic [7:0] OFS_DPH = 8'h83;
	localparam logic [7:0] OFS_FLAGS = 8'hD0;
	localparam logic [7:0] OFS_MAIN = 8'hF0;
	localparam logic [7:0] OFS_SECOND = 8'hF0;
	localparam logic [7:0] SFR_BASE = 8'h80;

	localparam logic [7:0] RST_STACK = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [15:0] RST_ZERO16 = 16'h0000;

	localparam int unsigned BIT_CY = 7;
	localparam int unsigned BIT_AC = 6;
	localparam int unsigned BIT_F0 = 5;
	localparam int unsigned BIT_BANK_HI = 4;
	localparam int unsigned BIT_BANK_LO = 3;
	localparam int unsigned BIT_OV = 2;
	localparam int unsigned BIT_F1 = 1;
	localparam int unsigned BIT_PAR = 0;

	localparam logic [2:0] CYC_MIN = 3'h1;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_NONE = 3'h0;
	localparam logic [7:0] STACK_STEP = 8'h01;
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	localparam logic [7:0] HIGH_ZERO = 8'h00;
	localparam logic [2:0] BANK_TOP_ZERO = 3'h0;

	typedef enum logic [3:0] {
		MODE_DIR = 4'h0,
		MODE_IND_RI = 4'h1,
		MODE_PUSH = 4'h2,
		MODE_POP = 4'h3,
		MODE_IND_DATA_POINTER_16 = 4'h4,
		MODE_REG = 4'h5,
		MODE_RSPEC = 4'h6,
		MODE_IMM = 4'h7,
		MODE_IDX_DATA_POINTER_16 = 4'h8,
		MODE_IDX_PC = 4'h9,
		MODE_JMP_IDX = 4'hA,
		MODE_DATA_POINTER_16_INC = 4'hB,
		MODE_DATA_POINTER_16_LOAD = 4'hC
	} ccra_mode_t;

	typedef enum logic [2:0] {
		SPACE_NONE = 3'h0,
		SPACE_IRAM = 3'h1,
		SPACE_SFR = 3'h2,
		SPACE_XRAM = 3'h3,
		SPACE_CODE = 3'h4
	} ccra_space_t;

	typedef enum logic [2:0] {
		BOP_NONE = 3'h0,
		BOP_CLR = 3'h1,
		BOP_SET = 3'h2,
		BOP_CPL = 3'h3,
		BOP_MOV = 3'h4,
		BOP_ANL = 3'h5,
		BOP_ORL = 3'h6
	} ccra_bitop_t;
endpackage
